// >>> common/bit_exec_pkg.sv
// Package for the bit test/skip and bit set execution block
// Overview of operation
// - On the test-skip-when-clear opcode the selected bit of the addressed register is examined and the next instruction is skipped when it is zero.
// - When skipping, the instruction word prefetched during the test is discarded and not executed.
// - A no-operation cycle replaces the discarded word, so the test takes one cycle or two when skipping.
// - The bit instructions carry a 7-bit register address (0 to 127) and a 3-bit bit position (0 to 7) in one word.
package bit_exec_pkg;
  localparam int         INSTR_W       = 14;
  localparam int         ADDR_W        = 7;
  localparam int         BITSEL_W      = 3;
  localparam int         DATA_W        = 8;
  localparam int         OPC_LSB       = 10;
  localparam int         BITSEL_LSB    = 7;
  localparam logic [3:0] OPC_TEST_CLR  = 4'h6;
  localparam logic [3:0] OPC_SET       = 4'h5;
  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

  typedef struct packed {
    logic [3:0]          opc;
    logic [BITSEL_W-1:0] bit_pos;
    logic [ADDR_W-1:0]   addr;
  } instr_fields_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_write_t;

  typedef enum logic [0:0] {
    ST_RUN   = 1'h0,
    ST_FLUSH = 1'h1
  } exec_state_t;
endpackage : bit_exec_pkg

// >>> design/bit_exec.sv
// Execution of the bit test/skip-when-clear and bit set instructions
`timescale 1ns/1ns
module bit_exec
  import bit_exec_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                instr_valid,
  input  wire logic [INSTR_W-1:0]  instr_word,
  output logic      [ADDR_W-1:0]   rd_addr,
  input  wire logic [DATA_W-1:0]   rd_data,
  output reg_write_t               reg_wr,
  output logic                     discard_fetch,
  output logic                     nop_cycle,
  output logic [INSTR_W-1:0]       exec_word
);

  // Split an instruction word into its fields; used for the bit select and the read and write address
  function automatic instr_fields_t split_word(input logic [INSTR_W-1:0] w);
    instr_fields_t f;
    f.opc     = w[INSTR_W-1:OPC_LSB];
    f.bit_pos = w[OPC_LSB-1:BITSEL_LSB];
    f.addr    = w[ADDR_W-1:0];
    return f;
  endfunction : split_word

  // Opcode class of a raw word; decode asks it for both instructions
  function automatic logic opc_is(input logic [INSTR_W-1:0] w,
                                  input logic [3:0]         opc);
    return (w[INSTR_W-1:OPC_LSB] == opc);
  endfunction : opc_is

  // Decoded fields and classes of the word on the bus this cycle
  instr_fields_t      f_now;
  logic               in_run;
  logic               is_test;
  logic               is_set;
  logic               bit_val;
  logic               skip_now;

  // Skip state
  exec_state_t        state_ff;
  exec_state_t        nxt_state;

  // Registered write towards the register file
  reg_write_t         wr_ff;
  reg_write_t         nxt_wr;

  // Word handed on to execution
  logic [INSTR_W-1:0] word_ff;
  logic [INSTR_W-1:0] nxt_word;

  // Field split; the address leaves at once so the read lands this cycle
  assign f_now   = split_word(instr_word);
  assign rd_addr = f_now.addr;

  // Decode only while running: a word shown in a flush cycle is the dropped one
  assign in_run  = (state_ff == ST_RUN);
  assign is_test = instr_valid && in_run && opc_is(instr_word, OPC_TEST_CLR);
  assign is_set  = instr_valid && in_run && opc_is(instr_word, OPC_SET);

  // Bit under test, and the skip decision
  assign bit_val  = rd_data[f_now.bit_pos];
  assign skip_now = is_test && !bit_val;

  // Skip state: a clear bit opens one flush cycle for the prefetched word
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (skip_now) begin
          nxt_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // Never longer than one cycle, so no second word is lost
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // Skip state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Skip outputs straight from the state flop, free of decode glitches
  assign discard_fetch = (state_ff == ST_FLUSH);
  assign nop_cycle     = (state_ff == ST_FLUSH);

  // A clear bit must skip
  a_skip_on_clear: assert property (@(posedge core_clk) disable iff (rst)
    is_test && !bit_val |=> discard_fetch)
    else $error("clear bit did not skip");

  // A set bit must not skip
  a_no_skip_set: assert property (@(posedge core_clk) disable iff (rst)
    is_test && bit_val |=> !discard_fetch)
    else $error("set bit skipped");

  // The flush is one cycle, two in all for a skipping test
  a_flush_one: assert property (@(posedge core_clk) disable iff (rst)
    discard_fetch |=> !discard_fetch)
    else $error("flush longer than one cycle");

  // A no-op cycle only ever follows a test that found its bit clear
  a_nop_pair: assert property (@(posedge core_clk) disable iff (rst)
    nop_cycle |-> $past(instr_valid) && ($past(instr_word[INSTR_W-1:OPC_LSB]) == OPC_TEST_CLR)
      && !$past(rd_data[instr_word[OPC_LSB-1:BITSEL_LSB]]))
    else $error("no-op without a skipping test");

  // A bit set never skips
  a_set_no_skip: assert property (@(posedge core_clk) disable iff (rst)
    is_set |=> !discard_fetch)
    else $error("bit set caused a skip");

  // Skip scenarios, back-to-back skips and a write straight after a flush
  c_skip:      cover property (@(posedge core_clk) disable iff (rst)
    is_test && !bit_val);
  c_noskp:     cover property (@(posedge core_clk) disable iff (rst)
    is_test && bit_val);
  c_back:      cover property (@(posedge core_clk) disable iff (rst)
    discard_fetch ##1 is_set);
  c_skip_skip: cover property (@(posedge core_clk) disable iff (rst)
    discard_fetch ##1 (is_test && !bit_val));

  // Executed word: the taken word, or a no-op when none is taken
  always_comb begin
    nxt_word = NOP_WORD;
    case (state_ff)
      ST_RUN: begin
        if (instr_valid) begin
          nxt_word = instr_word;
        end
      end
      ST_FLUSH: begin
        // The prefetched word is dropped and a no-op runs in its place
        nxt_word = NOP_WORD;
      end
      default: begin
        nxt_word = NOP_WORD;
      end
    endcase
  end

  // Executed word register; reset shows a no-op
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_ff <= NOP_WORD;
    end else begin
      word_ff <= nxt_word;
    end
  end

  // Data output from the flop
  assign exec_word = word_ff;

  // The dropped word must never reach execution
  a_flush_nop: assert property (@(posedge core_clk) disable iff (rst)
    discard_fetch |=> exec_word == NOP_WORD)
    else $error("flush did not insert nop");

  // A word taken outside a flush is passed on unchanged
  a_word_passed: assert property (@(posedge core_clk) disable iff (rst)
    instr_valid && !discard_fetch |=> exec_word == $past(instr_word))
    else $error("taken word not passed on");

  // Bit set: read-modify-write of the addressed register, one bit only
  always_comb begin
    nxt_wr = '0;
    if (is_set) begin
      // No status flags are touched, only the chosen bit
      nxt_wr.en   = 1'h1;
      nxt_wr.addr = f_now.addr;
      nxt_wr.data = rd_data | (DATA_W'(1) << f_now.bit_pos);
    end
  end

  // Write register; the write lands one cycle after the bit-set word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  // Write port from the flop
  assign reg_wr = wr_ff;

  // A bit set must write
  a_set_write: assert property (@(posedge core_clk) disable iff (rst)
    is_set |=> reg_wr.en)
    else $error("bit set write missing");

  // Only the chosen bit is raised, the rest read back unchanged
  a_set_bits: assert property (@(posedge core_clk) disable iff (rst)
    is_set |=> reg_wr.data == ($past(rd_data) | (DATA_W'(1) << $past(instr_word[OPC_LSB-1:BITSEL_LSB]))))
    else $error("bit set data wrong");

  // The write goes to the address field of the word
  a_addr_field: assert property (@(posedge core_clk) disable iff (rst)
    is_set |=> reg_wr.addr == $past(instr_word[ADDR_W-1:0]))
    else $error("address field wrong");

  // No write without a bit set
  a_no_stray_wr: assert property (@(posedge core_clk) disable iff (rst)
    !is_set |=> !reg_wr.en)
    else $error("unexpected write");

  // A dropped bit-set word must not write either
  a_flush_no_wr: assert property (@(posedge core_clk) disable iff (rst)
    discard_fetch |=> !reg_wr.en)
    else $error("dropped word wrote");

  // A plain bit set
  c_set:       cover property (@(posedge core_clk) disable iff (rst)
    is_set);

endmodule : bit_exec

// >>> tb/tb_top.sv
// Self-checking bench for the bit test/skip and bit set execution block
`timescale 1ns/1ns
module tb_top;
  import bit_exec_pkg::*;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr_word = '0;
  logic [DATA_W-1:0]  rd_data = '0;
  logic [ADDR_W-1:0]  rd_addr;
  reg_write_t         reg_wr;
  logic               discard_fetch;
  logic               nop_cycle;
  logic [INSTR_W-1:0] exec_word;
  logic [3:0]         opc;
  int                 num_errors = 0;
  int                 compares = 0;
  int                 flush, taken, skip, setw, bpos;
  int                 exp_q[$];
  int                 exp_word;

  bit_exec i_dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .rd_addr(rd_addr), .rd_data(rd_data), .reg_wr(reg_wr), .discard_fetch(discard_fetch),
    .nop_cycle(nop_cycle), .exec_word(exec_word));

  always #5 core_clk = ~core_clk;

  // One comparison, counted; a miss is reported at once
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic print_verdict;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog: the tests need about 6 us, so 60 us means a hang
  initial begin
    #60000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  // Test 0 always valid, test 1 gappy, test 2 all bits clear so every taken test skips and skips can follow back to back
  initial begin
    void'($urandom(32'h2C27));
    flush = 0;
    repeat (16) @(posedge core_clk);
    #1 chk(!reg_wr.en && !discard_fetch && exec_word === NOP_WORD, "reset values");
    @(negedge core_clk) rst = 1'b0;
    for (int t = 0; t < 3; t++) begin
      repeat (200) begin
        @(negedge core_clk);
        opc = ($urandom_range(3) < 2) ? ($urandom_range(1) ? OPC_TEST_CLR : OPC_SET) : 4'($urandom);
        instr_word = {opc, 3'($urandom), 7'($urandom)};
        instr_valid = (t == 1) ? 1'($urandom) : 1'b1;
        rd_data = (t == 2) ? 8'h00 : 8'($urandom);
        bpos = int'(instr_word[9:7]);
        // Model: a word shown during the flush cycle is the dropped one
        taken = (instr_valid && !flush) ? 1 : 0;
        skip = (taken && opc == OPC_TEST_CLR && !rd_data[bpos]) ? 1 : 0;
        setw = (taken && opc == OPC_SET) ? 1 : 0;
        // Expected executed word: the taken word, else a no-op
        exp_q.push_back(taken ? int'(instr_word) : int'(NOP_WORD));
        #1 chk(rd_addr === instr_word[ADDR_W-1:0], "read address");
        @(posedge core_clk);
        #1 chk(discard_fetch === 1'(skip) && nop_cycle === 1'(skip), "skip pulse");
        chk(reg_wr.en === 1'(setw), "write enable");
        if (setw) chk(reg_wr.addr === instr_word[6:0] && reg_wr.data === (rd_data | (8'h01 << bpos)), "set");
        exp_word = exp_q.pop_front();
        if (flush) chk(exec_word === NOP_WORD && exp_word == int'(NOP_WORD), "no-op after skip");
        else chk(exec_word === INSTR_W'(exp_word), "word passed on");
        flush = skip;
      end
      $display("test %0d done, errors so far %0d", t, num_errors);
    end
    print_verdict();
  end
endmodule : tb_top
